// ===== hw/idb_identify_builder.sv
/*
  Identify data builder: on an identify request it fills a 256-word record
  from APB-written configuration and live device state, then hands it to the
  host word by word.
  Assumes i_live and i_identify_req come from logic on i_clock, and an APB3
  master on the same clock.
*/
// Behaviour
// - Word 47: 80h high byte, low byte max sectors per interrupt, never 00h.
// - Word 48 bit 0 shows trusted computing support; bits 13:1 zero.
// - Word 49 bit 10 set when IORDY may be disabled.
// - Word 50: bit 15 clear, bit 14 set, bit 0 set.
// - Word 53 bit 2 set only when word 88 fields are valid.
// - Word 53 bit 1 set only when words 64 to 70 are valid.
// - Word 59 bit 8 marks valid multiple setting; bits 7:0 current count.
// - Words 60 and 61 hold user-addressable sector count.
// - Word 63 bits 10:8 follow selected multiword DMA mode.
// - Word 63 bits 2:0 are fixed multiword DMA support flags.
// - Words 65 to 68 hold the four cycle times in nanoseconds.
// - Word 75 bits 4:0 queue depth minus one; rest zero.
// - Word 81 carries minor revision; 0000h or FFFFh means none.
// - Bit 4 of words 82 and 85 is always zero.
// - Words 83, 84, 87: bit 15 zero, bit 14 one.
// - Word 83 bit 10 set when 48-bit addressing is supported.
// - Word 85 reflects enabled features; bit 0 tracks self-monitoring.
// - Word 85 bit 10 set when current max address below native max.
// - Word 86 bit 15 set when words 119 and 120 are valid.
// - Word 88 bits 14:8 flag the selected ultra DMA mode.
// - Word 88 bits 6:0 fixed support flags; bits 15 and 7 zero.
// - Words 89, 90 erase times; word 91 current power management level.
// - Reserved bits and words of the record read as zero.
// - Identify: busy, build record, data request, clear busy, then interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "idb_map.svh"

module idb_identify_builder (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_identify_req,
  output logic o_busy,
  output logic o_drq,
  output logic o_intrq,
  input wire logic i_word_rd,
  output logic [15:0] o_word_data,
  output logic o_word_valid,
  input wire idb_pkg::idb_live_t i_live
);

  idb_pkg::idb_state_t q;
  idb_pkg::idb_state_t d;
  logic ram_we;
  logic [7:0] ram_waddr;
  logic [15:0] ram_wdata;
  logic ram_re;
  logic [15:0] ram_rdata;
  logic apb_setup;
  logic apb_write;
  logic start;

  // Selected-mode flags; ultra DMA wins over multiword so only one is ever set.
  function automatic logic [9:0] sel_flags(input idb_pkg::idb_live_t l);
    logic [9:0] f;
    f = 10'h000;
    if (l.udma_on && (l.udma_mode <= `IDB_UDMA_TOP)) begin
      f[9:3] = 7'(7'h01 << l.udma_mode);
    end else if (l.mwdma_on && (l.mwdma_mode != 2'h3)) begin
      f[2:0] = 3'(3'h1 << l.mwdma_mode);
    end
    return f;
  endfunction

  function automatic logic [15:0] build_word(
    input logic [7:0] idx,
    input idb_pkg::idb_cfg_t c,
    input idb_pkg::idb_live_t l
  );
    logic [15:0] w;
    logic [9:0] sel;
    logic hpa;
    w = 16'h0000;
    sel = sel_flags(l);
    hpa = (l.cur_max_lba < l.native_max_lba);
    case (idx)
      `IDB_W_MULTI_MAX: w = {`IDB_W47_HIGH, c.max_mult};
      `IDB_W_TRUSTED: w = {15'h0000, c.flags[`IDB_FLAG_TRUSTED]};
      `IDB_W_CAP_A: begin
        w[13] = c.flags[`IDB_FLAG_STBY_STD];
        w[11] = c.flags[`IDB_FLAG_IORDY_SUP];
        w[10] = c.flags[`IDB_FLAG_IORDY_DIS];
        w[9] = c.flags[`IDB_FLAG_LBA_SUP];
        w[8] = c.flags[`IDB_FLAG_DMA_SUP];
      end
      `IDB_W_CAP_B: w = `IDB_W50_VALUE;
      `IDB_W_FIELD_VALID: begin
        w[2] = c.flags[`IDB_FLAG_UDMA_VALID];
        w[1] = c.flags[`IDB_FLAG_PIO_VALID];
      end
      `IDB_W_MULTI_CUR: w = {7'h00, l.mult_valid, l.mult_valid ? l.mult_count : 8'h00};
      `IDB_W_LBA_LO: w = c.capacity[15:0];
      `IDB_W_LBA_HI: w = c.capacity[31:16];
      `IDB_W_MWDMA: w = {5'h00, sel[2:0], 5'h00, c.mw_sup};
      `IDB_W_PIO: w = {8'h00, c.pio};
      `IDB_W_CYC_MW_MIN: w = c.cyc_mw_min;
      `IDB_W_CYC_MW_REC: w = c.cyc_mw_rec;
      `IDB_W_CYC_PIO: w = c.cyc_pio;
      `IDB_W_CYC_PIO_FC: w = c.cyc_pio_fc;
      `IDB_W_QDEPTH: w = {11'h000, c.qdepth};
      `IDB_W_MAJOR: w = c.major;
      `IDB_W_MINOR: w = c.minor;
      `IDB_W_CMD_SUP: w = c.cmd_sup & `IDB_PACKET_MASK;
      `IDB_W_CMD_SUP2: begin
        w = {`IDB_VALID_SIG, c.cmd_sup2[13:0]};
        w[10] = c.flags[`IDB_FLAG_LBA48];
      end
      `IDB_W_CMD_EXT: w = {`IDB_VALID_SIG, c.cmd_ext[13:0]};
      `IDB_W_CMD_EN: begin
        w = l.feat_en & `IDB_PACKET_MASK;
        w[10] = hpa;
        w[0] = l.smart_en;
      end
      `IDB_W_CMD_EN2: begin
        w = {1'b0, 1'b0, l.feat_en2[13:0]};
        w[15] = c.flags[`IDB_FLAG_W119_VALID];
      end
      `IDB_W_CMD_EN3: w = {`IDB_VALID_SIG, c.cmd_en3[13:0]};
      `IDB_W_UDMA: w = {1'b0, sel[9:3], 1'b0, c.udma_sup};
      `IDB_W_ERASE: w = c.erase;
      `IDB_W_ERASE_ENH: w = c.erase_enh;
      `IDB_W_APM: w = l.apm_level;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  idb_word_ram u_ram (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_we(ram_we),
    .i_waddr(ram_waddr),
    .i_wdata(ram_wdata),
    .i_re(ram_re),
    .i_raddr(q.rd_cnt[7:0]),
    .o_rdata(ram_rdata)
  );

  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && i_pwrite;
  assign start = i_identify_req ||
                 (apb_write && (i_paddr == `IDB_OFF_CTRL) && i_pwdata[`IDB_CTRL_START]);

  always_comb begin
    d = q;
    d.irq = 1'b0;
    d.rd_pend = 1'b0;
    ram_we = 1'b0;
    ram_waddr = q.idx;
    ram_wdata = build_word(q.idx, q.cfg, i_live);
    ram_re = 1'b0;

    // APB read data and error are captured in the setup cycle so they come from flops.
    if (apb_setup) begin
      d.prdata = 32'h0000_0000;
      d.slverr = 1'b0;
      case (i_paddr)
        `IDB_OFF_CTRL: d.prdata = 32'h0000_0000;
        `IDB_OFF_MULTI: d.prdata = {11'h000, q.cfg.qdepth, 8'h00, q.cfg.max_mult};
        `IDB_OFF_FLAGS: d.prdata = {22'h000000, q.cfg.flags};
        `IDB_OFF_MODES: d.prdata = {8'h00, q.cfg.pio, 1'b0, q.cfg.udma_sup, 5'h00, q.cfg.mw_sup};
        `IDB_OFF_CYC_A: d.prdata = {q.cfg.cyc_mw_rec, q.cfg.cyc_mw_min};
        `IDB_OFF_CYC_B: d.prdata = {q.cfg.cyc_pio_fc, q.cfg.cyc_pio};
        `IDB_OFF_REV: d.prdata = {q.cfg.minor, q.cfg.major};
        `IDB_OFF_CMD_A: d.prdata = {q.cfg.cmd_sup2, q.cfg.cmd_sup};
        `IDB_OFF_CMD_B: d.prdata = {q.cfg.cmd_en3, q.cfg.cmd_ext};
        `IDB_OFF_ERASE: d.prdata = {q.cfg.erase_enh, q.cfg.erase};
        `IDB_OFF_CAPACITY: d.prdata = q.cfg.capacity;
        `IDB_OFF_STATUS: begin
          d.prdata[`IDB_STAT_BUSY] = (q.phase == idb_pkg::IDB_BUILD);
          d.prdata[`IDB_STAT_DRQ] = (q.phase == idb_pkg::IDB_NOTIFY) ||
                                    (q.phase == idb_pkg::IDB_XFER);
          d.prdata[`IDB_STAT_PTR_LSB +: 9] = q.rd_cnt;
        end
        default: d.slverr = 1'b1;
      endcase
    end

    // Writes land at the access edge; the status word is read only.
    if (apb_write) begin
      case (i_paddr)
        `IDB_OFF_MULTI: begin
          if (i_pwdata[7:0] != 8'h00) begin
            d.cfg.max_mult = i_pwdata[7:0];
          end
          d.cfg.qdepth = i_pwdata[`IDB_MULTI_QD_LSB +: 5];
        end
        `IDB_OFF_FLAGS: d.cfg.flags = i_pwdata[9:0];
        `IDB_OFF_MODES: begin
          d.cfg.mw_sup = i_pwdata[2:0];
          d.cfg.udma_sup = i_pwdata[`IDB_MODES_UDMA_LSB +: 7];
          d.cfg.pio = i_pwdata[`IDB_MODES_PIO_LSB +: 8];
        end
        `IDB_OFF_CYC_A: begin
          d.cfg.cyc_mw_min = i_pwdata[15:0];
          d.cfg.cyc_mw_rec = i_pwdata[31:16];
        end
        `IDB_OFF_CYC_B: begin
          d.cfg.cyc_pio = i_pwdata[15:0];
          d.cfg.cyc_pio_fc = i_pwdata[31:16];
        end
        `IDB_OFF_REV: begin
          d.cfg.major = i_pwdata[15:0];
          d.cfg.minor = i_pwdata[31:16];
        end
        `IDB_OFF_CMD_A: begin
          d.cfg.cmd_sup = i_pwdata[15:0];
          d.cfg.cmd_sup2 = i_pwdata[31:16];
        end
        `IDB_OFF_CMD_B: begin
          d.cfg.cmd_ext = i_pwdata[15:0];
          d.cfg.cmd_en3 = i_pwdata[31:16];
        end
        `IDB_OFF_ERASE: begin
          d.cfg.erase = i_pwdata[15:0];
          d.cfg.erase_enh = i_pwdata[31:16];
        end
        `IDB_OFF_CAPACITY: d.cfg.capacity = i_pwdata;
        default: d.cfg = d.cfg;
      endcase
    end

    case (q.phase)
      idb_pkg::IDB_IDLE: begin
        if (start) begin
          d.phase = idb_pkg::IDB_BUILD;
          d.idx = 8'h00;
        end
      end
      idb_pkg::IDB_BUILD: begin
        // Live state is sampled word by word, so a record reflects the state
        // current at the moment each word was built.
        ram_we = 1'b1;
        d.idx = q.idx + 8'h01;
        if (q.idx == `IDB_W_LAST) begin
          d.phase = idb_pkg::IDB_NOTIFY;
          d.rd_cnt = 9'h000;
        end
      end
      idb_pkg::IDB_NOTIFY: begin
        d.irq = 1'b1;
        d.phase = idb_pkg::IDB_XFER;
      end
      idb_pkg::IDB_XFER: begin
        if (i_word_rd) begin
          ram_re = 1'b1;
          d.rd_pend = 1'b1;
          d.rd_cnt = q.rd_cnt + 9'h001;
          if (q.rd_cnt == (`IDB_WORD_COUNT - 9'h001)) begin
            d.phase = idb_pkg::IDB_IDLE;
          end
        end
      end
      default: d.phase = idb_pkg::IDB_IDLE;
    endcase

    // A software abort drops any record in progress or waiting to be read.
    if (apb_write && (i_paddr == `IDB_OFF_CTRL) && i_pwdata[`IDB_CTRL_ABORT]) begin
      d.phase = idb_pkg::IDB_IDLE;
      d.irq = 1'b0;
    end

    if (!i_rst_b) begin
      d = '0;
      d.phase = idb_pkg::IDB_IDLE;
      d.cfg.max_mult = `IDB_RST_MAX_MULT;
      d.cfg.qdepth = `IDB_RST_QDEPTH;
      d.cfg.flags = `IDB_RST_FLAGS;
      d.cfg.mw_sup = `IDB_RST_MW_SUP;
      d.cfg.udma_sup = `IDB_RST_UDMA_SUP;
      d.cfg.pio = `IDB_RST_PIO;
      d.cfg.cyc_mw_min = `IDB_RST_CYC;
      d.cfg.cyc_mw_rec = `IDB_RST_CYC;
      d.cfg.cyc_pio = `IDB_RST_CYC;
      d.cfg.cyc_pio_fc = `IDB_RST_CYC;
      d.cfg.major = `IDB_RST_REV;
      d.cfg.minor = `IDB_RST_REV;
      d.cfg.cmd_sup = `IDB_RST_CMD;
      d.cfg.cmd_sup2 = `IDB_RST_CMD;
      d.cfg.cmd_ext = `IDB_RST_CMD;
      d.cfg.cmd_en3 = `IDB_RST_CMD;
      d.cfg.erase = `IDB_RST_ERASE;
      d.cfg.erase_enh = `IDB_RST_ERASE;
      d.cfg.capacity = `IDB_RST_CAPACITY;
      ram_we = 1'b0;
      ram_re = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    q <= d;
  end

  // Zero wait states: every access completes in its first access cycle.
  assign o_pready = 1'b1;
  assign o_prdata = q.prdata;
  assign o_pslverr = q.slverr && i_psel && i_penable;
  assign o_busy = (q.phase == idb_pkg::IDB_BUILD);
  assign o_drq = (q.phase == idb_pkg::IDB_NOTIFY) || (q.phase == idb_pkg::IDB_XFER);
  assign o_intrq = q.irq;
  assign o_word_data = ram_rdata;
  assign o_word_valid = q.rd_pend;

endmodule

`default_nettype wire

// ===== hw/idb_map.svh
/*
  Address map, field positions, reset values and record word indices for the
  identify data builder. Assumes an 8-bit APB byte address and a 16-bit record.
*/
`ifndef IDB_MAP_SVH
`define IDB_MAP_SVH

// APB byte offsets, one aligned 32-bit word each.
`define IDB_OFF_CTRL 8'h00
`define IDB_OFF_MULTI 8'h04
`define IDB_OFF_FLAGS 8'h08
`define IDB_OFF_MODES 8'h0C
`define IDB_OFF_CYC_A 8'h10
`define IDB_OFF_CYC_B 8'h14
`define IDB_OFF_REV 8'h18
`define IDB_OFF_CMD_A 8'h1C
`define IDB_OFF_CMD_B 8'h20
`define IDB_OFF_ERASE 8'h24
`define IDB_OFF_CAPACITY 8'h28
`define IDB_OFF_STATUS 8'h2C

// Field positions inside the control, configuration and status registers.
`define IDB_CTRL_START 0
`define IDB_CTRL_ABORT 1
`define IDB_MULTI_QD_LSB 16
`define IDB_FLAG_TRUSTED 0
`define IDB_FLAG_IORDY_DIS 1
`define IDB_FLAG_UDMA_VALID 2
`define IDB_FLAG_PIO_VALID 3
`define IDB_FLAG_LBA48 4
`define IDB_FLAG_W119_VALID 5
`define IDB_FLAG_IORDY_SUP 6
`define IDB_FLAG_LBA_SUP 7
`define IDB_FLAG_DMA_SUP 8
`define IDB_FLAG_STBY_STD 9
`define IDB_MODES_UDMA_LSB 8
`define IDB_MODES_PIO_LSB 16
`define IDB_STAT_BUSY 0
`define IDB_STAT_DRQ 1
`define IDB_STAT_PTR_LSB 2

// Reset values.
`define IDB_RST_MAX_MULT 8'h10
`define IDB_RST_QDEPTH 5'h1F
`define IDB_RST_FLAGS 10'h3FF
`define IDB_RST_MW_SUP 3'h7
`define IDB_RST_UDMA_SUP 7'h7F
`define IDB_RST_PIO 8'h03
`define IDB_RST_CYC 16'h0078
`define IDB_RST_REV 16'h0000
`define IDB_RST_CMD 16'h0000
`define IDB_RST_ERASE 16'h0000
`define IDB_RST_CAPACITY 32'h0000_0000

// Constant parts of the record.
`define IDB_W47_HIGH 8'h80
`define IDB_W50_VALUE 16'h4001
`define IDB_VALID_SIG 2'h1
`define IDB_PACKET_MASK 16'hFFEF
`define IDB_UDMA_TOP 3'h6

// Record word indices.
`define IDB_W_MULTI_MAX 8'h2F
`define IDB_W_TRUSTED 8'h30
`define IDB_W_CAP_A 8'h31
`define IDB_W_CAP_B 8'h32
`define IDB_W_FIELD_VALID 8'h35
`define IDB_W_MULTI_CUR 8'h3B
`define IDB_W_LBA_LO 8'h3C
`define IDB_W_LBA_HI 8'h3D
`define IDB_W_MWDMA 8'h3F
`define IDB_W_PIO 8'h40
`define IDB_W_CYC_MW_MIN 8'h41
`define IDB_W_CYC_MW_REC 8'h42
`define IDB_W_CYC_PIO 8'h43
`define IDB_W_CYC_PIO_FC 8'h44
`define IDB_W_QDEPTH 8'h4B
`define IDB_W_MAJOR 8'h50
`define IDB_W_MINOR 8'h51
`define IDB_W_CMD_SUP 8'h52
`define IDB_W_CMD_SUP2 8'h53
`define IDB_W_CMD_EXT 8'h54
`define IDB_W_CMD_EN 8'h55
`define IDB_W_CMD_EN2 8'h56
`define IDB_W_CMD_EN3 8'h57
`define IDB_W_UDMA 8'h58
`define IDB_W_ERASE 8'h59
`define IDB_W_ERASE_ENH 8'h5A
`define IDB_W_APM 8'h5B
`define IDB_W_LAST 8'hFF
`define IDB_WORD_COUNT 9'h100

`endif

// ===== hw/idb_pkg.sv
/*
  Types of the identify data builder: phases, configuration, live device
  state and the whole registered state of the top module.
  Assumes the constants of idb_map.svh are included where values are needed.
*/
package idb_pkg;

  typedef enum logic [1:0] {
    IDB_IDLE,
    IDB_BUILD,
    IDB_NOTIFY,
    IDB_XFER
  } idb_phase_t;

  // Live device state, same clock as the builder.
  typedef struct packed {
    logic smart_en;
    logic [15:0] feat_en;
    logic [15:0] feat_en2;
    logic mult_valid;
    logic [7:0] mult_count;
    logic mwdma_on;
    logic [1:0] mwdma_mode;
    logic udma_on;
    logic [2:0] udma_mode;
    logic [47:0] cur_max_lba;
    logic [47:0] native_max_lba;
    logic [15:0] apm_level;
  } idb_live_t;

  typedef struct packed {
    logic [7:0] max_mult;
    logic [4:0] qdepth;
    logic [9:0] flags;
    logic [2:0] mw_sup;
    logic [6:0] udma_sup;
    logic [7:0] pio;
    logic [15:0] cyc_mw_min;
    logic [15:0] cyc_mw_rec;
    logic [15:0] cyc_pio;
    logic [15:0] cyc_pio_fc;
    logic [15:0] major;
    logic [15:0] minor;
    logic [15:0] cmd_sup;
    logic [15:0] cmd_sup2;
    logic [15:0] cmd_ext;
    logic [15:0] cmd_en3;
    logic [15:0] erase;
    logic [15:0] erase_enh;
    logic [31:0] capacity;
  } idb_cfg_t;

  typedef struct packed {
    idb_phase_t phase;
    logic [7:0] idx;
    logic [8:0] rd_cnt;
    logic rd_pend;
    logic irq;
    logic [31:0] prdata;
    logic slverr;
    idb_cfg_t cfg;
  } idb_state_t;

endpackage

// ===== hw/idb_word_ram.sv
/*
  256 x 16 record memory with one write port and a registered read port.
  Assumes writer and reader share i_clock; read data appear one edge after
  the read enable.
*/
`timescale 1ns/1ps
`default_nettype none

module idb_word_ram (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic i_re,
  input wire logic [7:0] i_raddr,
  output logic [15:0] o_rdata
);

  logic [15:0] mem [0:255];
  logic [15:0] rdata_q;

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // The memory array itself is not reset; only the output register is.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rdata_q <= 16'h0000;
    end else if (i_re) begin
      rdata_q <= mem[i_raddr];
    end
  end

  assign o_rdata = rdata_q;

endmodule

`default_nettype wire

// ===== tb/idb_builder_chk.sv
/* Port checker for the identify data builder.
   Assumes it is bound to idb_identify_builder and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module idb_builder_chk (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_identify_req,
  input wire logic o_busy,
  input wire logic o_drq,
  input wire logic o_intrq,
  input wire logic i_word_rd,
  input wire logic [15:0] o_word_data,
  input wire logic o_word_valid,
  input wire idb_pkg::idb_live_t i_live
);
  logic [9:0] busy_len_q;
  logic [8:0] widx_q;
  logic [2:0] mw_sel_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Index of the word on the output, counted from the start of each transfer.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || !o_busy) begin
      busy_len_q <= 10'h000;
    end else begin
      busy_len_q <= busy_len_q + 10'h001;
    end
    if (!i_rst_b || (!o_drq && !o_word_valid)) begin
      widx_q <= 9'h000;
    end else if (o_word_valid) begin
      widx_q <= widx_q + 9'h001;
    end
    if (o_word_valid && widx_q == 9'h03F) begin
      mw_sel_q <= o_word_data[10:8];
    end
  end
  sequence notify_s;
    o_drq && !o_busy ##1 o_intrq ##1 !o_intrq;
  endsequence
  busy_len_a: assert property ($fell(o_busy) |-> busy_len_q == 10'h100)
    else $error("busy length wrong");
  notify_a: assert property ($fell(o_busy) |-> notify_s)
    else $error("request and interrupt order wrong");
  start_a: assert property (i_identify_req && !o_busy && !o_drq |=> o_busy)
    else $error("identify not started");
  valid_a: assert property (o_word_valid |-> $past(i_word_rd) && $past(o_drq))
    else $error("word valid without read");
  xfer_a: assert property (i_word_rd && o_drq && !$past(o_busy) |=> o_word_valid)
    else $error("read not answered");
  w47_a: assert property (o_word_valid && widx_q == 9'h02F |->
    o_word_data[15:8] == 8'h80 && o_word_data[7:0] != 8'h00) else $error("word 47 wrong");
  w50_a: assert property (o_word_valid && widx_q == 9'h032 |-> o_word_data == 16'h4001)
    else $error("word 50 wrong");
  sig_a: assert property (o_word_valid && (widx_q == 9'h053 || widx_q == 9'h054 ||
    widx_q == 9'h057) |-> o_word_data[15:14] == 2'h1) else $error("signature bits wrong");
  pkt_a: assert property (o_word_valid && (widx_q == 9'h052 || widx_q == 9'h055)
    |-> !o_word_data[4]) else $error("packet bit set");
  hpa_a: assert property (o_word_valid && widx_q == 9'h055 |-> o_word_data[0] ==
    i_live.smart_en && o_word_data[10] == (i_live.cur_max_lba < i_live.native_max_lba))
    else $error("word 85 wrong");
  one_mode_a: assert property (o_word_valid && widx_q == 9'h058 |->
    $countones({mw_sel_q, o_word_data[14:8]}) <= 1) else $error("two modes selected");
  rsvd_a: assert property (o_word_valid && widx_q > 9'h05B |-> o_word_data == 16'h0000)
    else $error("reserved word not zero");
endmodule
bind idb_identify_builder idb_builder_chk i_chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_identify_req(i_identify_req), .o_busy(o_busy), .o_drq(o_drq), .o_intrq(o_intrq),
  .i_word_rd(i_word_rd), .o_word_data(o_word_data), .o_word_valid(o_word_valid),
  .i_live(i_live));
`default_nettype wire

// ===== tb/idb_host_model.sv
/* Host model: issues identify and reads the 256-word record, fast or slow.
   Assumes the same clock as the builder; tasks are entered at a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module idb_host_model (
  input wire logic i_clock,
  input wire logic i_intrq,
  input wire logic i_word_valid,
  input wire logic [15:0] i_word_data,
  output logic o_identify_req,
  output logic o_word_rd
);
  logic [15:0] mem [256];
  int n_got;
  initial begin
    o_identify_req = 1'b0;
    o_word_rd = 1'b0;
  end
  task automatic identify(input bit slow);
    int issued;
    int t;
    bit rd;
    issued = 0;
    t = 0;
    n_got = 0;
    o_identify_req <= 1'b1;
    @(posedge i_clock);
    o_identify_req <= 1'b0;
    while (i_intrq !== 1'b1) begin
      @(posedge i_clock);
      t++;
    end
    while (n_got < 256) begin
      rd = issued < 256 && (!slow || t % 3 == 0);
      o_word_rd <= rd;
      issued += rd;
      @(posedge i_clock);
      t++;
      if (i_word_valid === 1'b1) begin
        mem[n_got] = i_word_data;
        n_got++;
      end
    end
    o_word_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_identify_data_builder.sv
/* Bench for the identify data builder: APB setup, then ten identify runs.
   Assumes the checker is bound and the host model reads the record. */
`timescale 1ns/1ps
`default_nettype none
`include "idb_map.svh"
module tb_identify_data_builder;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, busy, drq, intrq;
  logic word_rd, word_valid, id_req, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] word_data;
  idb_pkg::idb_live_t live;
  int errors, n_tests, cycles;
  logic [39:0] cfg_tab [8] = '{40'h0C_0007_3F03, 40'h10_0096_00B4, 40'h14_0064_00F0,
    40'h18_0028_01F0, 40'h1C_8C69_747B, 40'h20_0163_8003, 40'h24_0010_0020, 40'h28_0EE7_C2B0};
  idb_identify_builder i_dut (.i_clock(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_identify_req(id_req),
    .o_busy(busy), .o_drq(drq), .o_intrq(intrq), .i_word_rd(word_rd),
    .o_word_data(word_data), .o_word_valid(word_valid), .i_live(live));
  idb_host_model u_host (.i_clock(clk), .i_intrq(intrq), .i_word_valid(word_valid),
    .i_word_data(word_data), .o_identify_req(id_req), .o_word_rd(word_rd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the cycle ceiling ends a hang.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] exp_word(input int w, input logic [9:0] f,
                                          input logic [4:0] qd);
    logic [2:0] mw;
    logic [6:0] us;
    mw = (!live.udma_on && live.mwdma_mode != 2'h3) ? 3'(1 << live.mwdma_mode) : 3'h0;
    us = (live.udma_on && live.udma_mode != 3'h7) ? 7'(1 << live.udma_mode) : 7'h00;
    case (w)
      47: return 16'h8020;
      48: return {15'h0000, f[0]};
      49: return {2'h0, f[9], 1'b0, f[6], f[1], f[7], f[8], 8'h00};
      50: return 16'h4001;
      53: return {13'h0000, f[2], f[3], 1'b0};
      59: return {7'h00, live.mult_valid, live.mult_count};
      60: return 16'hC2B0;
      61: return 16'h0EE7;
      63: return {5'h00, mw, 5'h00, 3'h3};
      64: return 16'h0007;
      65: return 16'h00B4;
      66: return 16'h0096;
      67: return 16'h00F0;
      68: return 16'h0064;
      75: return {11'h000, qd};
      80: return 16'h01F0;
      81: return 16'h0028;
      82: return 16'h746B;
      83: return {5'h09, f[4], 10'h069};
      84: return 16'h4003;
      85: return {5'h02, live.cur_max_lba < live.native_max_lba, 5'h13, 4'h4, live.smart_en};
      86: return {f[5], 15'h3C21};
      87: return 16'h4163;
      88: return {1'b0, us, 8'h3F};
      89: return 16'h0020;
      90: return 16'h0010;
      91: return live.apm_level;
      default: return 16'h0000;
    endcase
  endfunction
  initial begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    live = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, `IDB_OFF_MULTI, 32'h0000_0000, rd, err);
    check("multi reset", rd, 32'h001F_0010);
    apb(1'b0, `IDB_OFF_FLAGS, 32'h0000_0000, rd, err);
    check("flags reset", rd, 32'h0000_03FF);
    apb(1'b1, 8'h40, 32'h0000_FFFF, rd, err);
    check("unmapped error", err, 1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, cfg_tab[i][39:32], cfg_tab[i][31:0], rd, err);
    end
    apb(1'b0, `IDB_OFF_CYC_A, 32'h0000_0000, rd, err);
    check("cycle times", rd, 32'h0096_00B4);
    $display("Test registers done, mismatches %0d", errors);
    for (int p = 0; p < 10; p++) begin
      apb(1'b1, `IDB_OFF_MULTI, p[0] ? 32'h001F_0000 : 32'h0005_0020, rd, err);
      apb(1'b1, `IDB_OFF_FLAGS, p[0] ? 32'h0000_015A : 32'h0000_02A5, rd, err);
      live <= '{~p[0], 16'h1679, 16'h3C21, 1'b1, 8'(p + 1), 1'b1, 2'(p % 3), p >= 3,
        3'(p - 3), 48'h0EE7_C2B0 - 48'(p[0]), 48'h0EE7_C2B0, 16'(p + 16'h0080)};
      u_host.identify(p[0]);
      check("words read", 32'(u_host.n_got), 256);
      @(posedge clk);
      check("drq after last word", drq, 0);
      for (int w = 0; w < 256; w++) begin
        check($sformatf("word %0d", w), u_host.mem[w], exp_word(w, p[0] ? 10'h15A : 10'h2A5,
          p[0] ? 5'h1F : 5'h05));
      end
      $display("Test identify %0d done, mismatches %0d", p, errors);
    end
    // Start from the control register, then abort while the record waits to be read.
    apb(1'b1, `IDB_OFF_CTRL, 32'h0000_0001, rd, err);
    apb(1'b0, `IDB_OFF_STATUS, 32'h0000_0000, rd, err);
    check("status building", rd, 32'h0000_0401);
    repeat (260) @(posedge clk);
    apb(1'b0, `IDB_OFF_STATUS, 32'h0000_0000, rd, err);
    check("status request", rd, 32'h0000_0002);
    check("drq before abort", drq, 1);
    apb(1'b1, `IDB_OFF_CTRL, 32'h0000_0002, rd, err);
    apb(1'b0, `IDB_OFF_STATUS, 32'h0000_0000, rd, err);
    check("status aborted", rd, 32'h0000_0000);
    check("drq after abort", drq, 0);
    $display("Test control done, mismatches %0d", errors);
    conclude();
  end
endmodule
`default_nettype wire
